/* File: rtl/mur_midi_uart.sv */
// Function
// - Byte data register: write sends, read receives
// - Write at shared address updates control
// - Read at shared address returns status
// - Status receive interrupt bit shows pending
// - Four status bits always read zero
// - Status transmit interrupt bit shows pending
// - Status transmit ready bit shows acceptance
// - Status receive ready shows byte available
// - Receive interrupt enable control bit
// - Transmit field 01 enables ready interrupt
// - Command field 11 resets serial port
// - Test bit selects fast bus clock rate
// - Test bit clear after reset
// - Module enable gates serial port operation
// - Pending interrupt drives serial interrupt output
`timescale 1ns/10ps
`include "mur_params.svh"

module mur_midi_uart
    import mur_pkg::*;
#(
    parameter int BIT_CYCLES  = `MUR_BIT_CYCLES,
    parameter int TEST_CYCLES = `MUR_TEST_CYCLES
)
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    output logic      [7:0] io_rdata,
    input  wire logic       port_enable,
    input  wire logic       midi_in,
    output logic            midi_out,
    output logic            serial_irq
);

    localparam logic [11:0] BIT_P  = 12'(BIT_CYCLES - 1);
    localparam logic [11:0] TEST_P = 12'(TEST_CYCLES - 1);
    localparam logic [11:0] HALF_P = 12'(BIT_CYCLES / 2 - 1);
    localparam logic [11:0] THALF_P = 12'(TEST_CYCLES / 2 - 1);

    logic [7:0]    ctrl_ff;
    logic          test_ff;
    mur_byte_t     rdata_ff;
    logic          irq_ff;
    logic          rx_meta_ff;
    logic          rx_sync_ff;
    logic          rx_prev_ff;
    mur_rx_state_e rx_state_ff;
    logic [11:0]   rx_cnt_ff;
    logic [2:0]    rx_bit_ff;
    mur_byte_t     rx_shift_ff;
    mur_byte_t     rx_data_ff;
    logic          rx_rdy_ff;
    mur_byte_t     thr_ff;
    logic          thr_full_ff;
    logic          tx_busy_ff;
    logic [9:0]    tx_shift_ff;
    logic [3:0]    tx_bit_ff;
    logic [11:0]   tx_cnt_ff;
    logic          tx_line_ff;

    // Address decode
    wire sel_data  = io_addr == `MUR_OFS_DATA;
    wire sel_cs    = io_addr == `MUR_OFS_CTRL_STAT;
    wire sel_test  = io_addr == `MUR_OFS_TEST;
    wire wr_data   = io_wr && sel_data;
    wire rd_data   = io_rd && sel_data;
    wire wr_ctrl   = io_wr && sel_cs;
    wire wr_test   = io_wr && sel_test;

    // Software reset pulses; disable holds the engine idle
    wire sw_reset  = wr_ctrl && io_wdata[`MUR_CTRL_CMD_HI:`MUR_CTRL_CMD_LO] == `MUR_CMD_SWRESET;
    wire eng_clr   = sw_reset || !port_enable;

    // Bit period from the fast bus clock in test mode
    wire [11:0] per    = test_ff ? TEST_P : BIT_P;
    wire [11:0] half   = test_ff ? THALF_P : HALF_P;

    wire rx_irq  = rx_rdy_ff && ctrl_ff[`MUR_CTRL_RX_IEN];
    wire tx_rdy  = !thr_full_ff;
    wire tx_irq  = tx_rdy && port_enable
                 && ctrl_ff[`MUR_CTRL_TX_HI:`MUR_CTRL_TX_LO] == `MUR_TX_IEN_CODE;

    // Status layout; bits 6:3 fixed zero as a presence signature
    wire [7:0] status = {rx_irq, 4'h0, tx_irq, tx_rdy && port_enable, rx_rdy_ff};

    wire [7:0] rd_mux = sel_data ? rx_data_ff
                      : sel_cs   ? status
                      : sel_test ? {7'h00, test_ff}
                      : 8'h00;

    // Receive framing
    wire rx_tick      = rx_cnt_ff == 12'h000;
    wire rx_fall      = rx_prev_ff && !rx_sync_ff;
    wire rx_done      = rx_state_ff == MUR_RX_STOP && rx_tick && rx_sync_ff;

    // Transmit framing
    wire tx_load      = !tx_busy_ff && thr_full_ff && port_enable;
    wire tx_tick      = tx_cnt_ff == 12'h000;
    wire tx_last      = tx_busy_ff && tx_tick && tx_bit_ff == 4'h9;

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ctrl_ff  <= `MUR_CTRL_RESET;
            test_ff  <= `MUR_TEST_RESET;
            rdata_ff <= 8'h00;
            irq_ff   <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_ff <= io_wdata;
            if (wr_test)
                test_ff <= io_wdata[`MUR_TEST_BIT];
            if (io_rd)
                rdata_ff <= rd_mux;
            irq_ff <= rx_irq || tx_irq;
        end
    end

    // Pin synchroniser
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            rx_meta_ff <= 1'b1;
            rx_sync_ff <= 1'b1;
            rx_prev_ff <= 1'b1;
        end
        else
        begin
            rx_meta_ff <= midi_in;
            rx_sync_ff <= rx_meta_ff;
            rx_prev_ff <= rx_sync_ff;
        end
    end

    // Receiver: start edge, sample mid-bit, LSB first
    always_ff @(posedge mclk)
    begin
        if (!rst_n || eng_clr)
        begin
            rx_state_ff <= MUR_RX_IDLE;
            rx_cnt_ff   <= 12'h000;
            rx_bit_ff   <= 3'h0;
            rx_shift_ff <= 8'h00;
        end
        else
        begin
            rx_cnt_ff <= rx_tick ? per : rx_cnt_ff - 12'h001;
            case (rx_state_ff)
                MUR_RX_IDLE:
                begin
                    if (rx_fall)
                    begin
                        rx_state_ff <= MUR_RX_START;
                        rx_cnt_ff   <= half;
                    end
                end
                MUR_RX_START:
                begin
                    if (rx_tick)
                        rx_state_ff <= rx_sync_ff ? MUR_RX_IDLE : MUR_RX_DATA;
                end
                MUR_RX_DATA:
                begin
                    if (rx_tick)
                    begin
                        rx_shift_ff <= {rx_sync_ff, rx_shift_ff[7:1]};
                        rx_bit_ff   <= rx_bit_ff + 3'h1;
                        if (rx_bit_ff == 3'h7)
                            rx_state_ff <= MUR_RX_STOP;
                    end
                end
                MUR_RX_STOP:
                begin
                    // A framing error drops the byte silently
                    if (rx_tick)
                        rx_state_ff <= MUR_RX_IDLE;
                end
                default:
                    rx_state_ff <= MUR_RX_IDLE;
            endcase
        end
    end

    // Receive holding byte; new byte wins over a clearing read
    always_ff @(posedge mclk)
    begin
        if (!rst_n || sw_reset)
        begin
            rx_data_ff <= 8'h00;
            rx_rdy_ff  <= 1'b0;
        end
        else if (rx_done)
        begin
            rx_data_ff <= rx_shift_ff;
            rx_rdy_ff  <= 1'b1;
        end
        else if (rd_data)
            rx_rdy_ff <= 1'b0;
    end

    // Transmit holding byte; ready drops until moved to shifter
    always_ff @(posedge mclk)
    begin
        if (!rst_n || sw_reset)
        begin
            thr_ff      <= 8'h00;
            thr_full_ff <= 1'b0;
        end
        else if (wr_data)
        begin
            thr_ff      <= io_wdata;
            thr_full_ff <= 1'b1;
        end
        else if (tx_load)
            thr_full_ff <= 1'b0;
    end

    // Transmit shifter: start, 8 data LSB first, stop
    always_ff @(posedge mclk)
    begin
        if (!rst_n || eng_clr)
        begin
            tx_busy_ff  <= 1'b0;
            tx_shift_ff <= 10'h3ff;
            tx_bit_ff   <= 4'h0;
            tx_cnt_ff   <= 12'h000;
            tx_line_ff  <= 1'b1;
        end
        else if (tx_load)
        begin
            tx_busy_ff  <= 1'b1;
            tx_shift_ff <= {1'b1, thr_ff, 1'b0};
            tx_bit_ff   <= 4'h0;
            tx_cnt_ff   <= per;
            tx_line_ff  <= 1'b0;
        end
        else if (tx_busy_ff)
        begin
            tx_cnt_ff <= tx_tick ? per : tx_cnt_ff - 12'h001;
            if (tx_last)
            begin
                tx_busy_ff <= 1'b0;
                tx_line_ff <= 1'b1;
            end
            else if (tx_tick)
            begin
                tx_shift_ff <= {1'b1, tx_shift_ff[9:1]};
                tx_bit_ff   <= tx_bit_ff + 4'h1;
                tx_line_ff  <= tx_shift_ff[1];
            end
        end
    end

    assign io_rdata   = rdata_ff;
    assign midi_out   = tx_line_ff;
    assign serial_irq = irq_ff;

endmodule : mur_midi_uart

/* File: rtl/mur_params.svh */
`ifndef MUR_PARAMS_SVH
`define MUR_PARAMS_SVH

`define MUR_OFS_DATA       8'h08
`define MUR_OFS_CTRL_STAT  8'h09
`define MUR_OFS_TEST       8'h0a

`define MUR_STAT_RX_IRQ    7
`define MUR_STAT_TX_IRQ    2
`define MUR_STAT_TX_RDY    1
`define MUR_STAT_RX_RDY    0

`define MUR_CTRL_RX_IEN    7
`define MUR_CTRL_TX_HI     6
`define MUR_CTRL_TX_LO     5
`define MUR_CTRL_CMD_HI    1
`define MUR_CTRL_CMD_LO    0

`define MUR_TX_IEN_CODE    2'h1
`define MUR_CMD_SWRESET    2'h3
`define MUR_TEST_BIT       0

`define MUR_CTRL_RESET     8'h00
`define MUR_TEST_RESET     1'h0

`define MUR_CLK_PS         8000
`define MUR_BIT_PS         32000000
`define MUR_BIT_CYCLES     (`MUR_BIT_PS / `MUR_CLK_PS)
`define MUR_TEST_CYCLES    16

`endif

/* File: rtl/mur_pkg.sv */
package mur_pkg;

    typedef enum logic [1:0] {
        MUR_RX_IDLE,
        MUR_RX_START,
        MUR_RX_DATA,
        MUR_RX_STOP
    } mur_rx_state_e;

    typedef logic [7:0] mur_byte_t;

endpackage : mur_pkg

/* File: verification/mur_midi_peer.sv */
`timescale 1ns/10ps
module mur_midi_peer #(parameter int FAST = 16, parameter int SLOW = 40)
(
    input  wire logic       mclk,
    input  wire logic       fast,
    input  wire logic       midi_out,
    output logic            midi_in,
    output logic [7:0]      got,
    output logic            got_ok
);
    int bit_len;
    // Bit length follows the test bit the bench has written
    assign bit_len = fast ? FAST : SLOW;
    initial {midi_in, got_ok} = 2'b10;
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge mclk) midi_in <= i == 0 ? 1'b0 : (i == 9 ? 1'b1 : b[i - 1]);
            repeat (bit_len - 1) @(posedge mclk);
        end
    endtask : send
    // Sample mid-bit so slow edges of the design do not matter
    always @(negedge midi_out)
    begin
        repeat (bit_len / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (bit_len) @(posedge mclk);
            got[i] <= midi_out;
        end
        repeat (bit_len) @(posedge mclk);
        got_ok <= midi_out;
        @(posedge mclk) got_ok <= 1'b0;
    end
endmodule : mur_midi_peer

/* File: verification/mur_midi_uart_properties.sv */
`timescale 1ns/10ps
module mur_midi_uart_properties
(
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_rdata,
    input wire logic       port_enable,
    input wire logic       midi_in,
    input wire logic       midi_out,
    input wire logic       serial_irq
);
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire stat_rd = io_rd && io_addr == 8'h09;
    a_stat_zero: assert property (stat_rd |=> io_rdata[6:3] == 4'h0)
        else $error("zero field set");
    a_unmapped_zero: assert property (io_rd && io_addr > 8'h0a |=> io_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved");
    a_rx_irq_rdy: assert property (stat_rd |=> !io_rdata[7] || io_rdata[0])
        else $error("rx irq without ready");
    a_tx_irq_rdy: assert property (stat_rd |=> !io_rdata[2] || io_rdata[1])
        else $error("tx irq without ready");
    a_off_not_ready: assert property (stat_rd && !port_enable |=> io_rdata[2:1] == 2'h0)
        else $error("disabled tx ready");
    a_off_idle: assert property (!port_enable |=> midi_out)
        else $error("disabled line low");
    a_irq_quiet: assert property (io_wr && io_addr == 8'h09 && !io_wdata[7]
        && io_wdata[6:5] != 2'h1 |=> ##1 !serial_irq) else $error("irq not masked");
    a_read_clears: assert property (io_rd && io_addr == 8'h08 ##2 stat_rd
        |=> !io_rdata[0]) else $error("rx ready kept");
endmodule : mur_midi_uart_properties

/* File: verification/test_midi_uart_regs.sv */
`timescale 1ns/10ps
module test_midi_uart_regs;
    logic       mclk, rst_n, io_wr, io_rd, port_enable, midi_in, midi_out, serial_irq;
    logic [7:0] io_addr, io_wdata, io_rdata, got, b;
    logic       got_ok, rd_seen, fast;
    logic [7:0] exp_q[$];
    logic [7:0] tx_q[$];
    int         fail_count, checked, n;
    mur_midi_uart #(.BIT_CYCLES(40), .TEST_CYCLES(16)) i_mur_midi_uart (.mclk(mclk),
        .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_rdata(io_rdata), .port_enable(port_enable), .midi_in(midi_in),
        .midi_out(midi_out), .serial_irq(serial_irq));
    mur_midi_peer #(.FAST(16), .SLOW(40)) i_mur_midi_peer (.mclk(mclk), .fast(fast),
        .midi_out(midi_out), .midi_in(midi_in), .got(got), .got_ok(got_ok));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checked++;
        if (seen !== want)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h want %h", $time, seen, want);
        end
    endtask : check
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= wr;
        io_rd <= !wr;
        @(posedge mclk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
    endtask : access
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        access(1'b0, a, 8'h00);
    endtask : rd
    task automatic test_done();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic wait_for(input bit irq);
        for (n = 0; n < 3000 && (irq ? serial_irq !== 1'b1 : tx_q.size() != 0); n++)
            @(posedge mclk);
        if (n == 3000)
        begin
            fail_count++;
            test_done();
        end
    endtask : wait_for
    always @(posedge mclk)
    begin
        if (rd_seen)
            check(io_rdata, exp_q.pop_front());
        if (got_ok === 1'b1)
            check(got, tx_q.pop_front());
        rd_seen <= io_rd;
    end
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial
    begin
        {io_wr, io_rd, io_addr, io_wdata, port_enable, rst_n, rd_seen, fast} = '0;
        void'($urandom(13));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        port_enable <= 1'b1;
        rd(8'h09, 8'h02);
        rd(8'h0a, 8'h00);
        rd(8'h0b, 8'h00);
        access(1'b1, 8'h0a, 8'hff);
        fast <= 1'b1;
        rd(8'h0a, 8'h01);
        access(1'b1, 8'h09, 8'h20);
        rd(8'h09, 8'h06);
        // Second byte waits behind a busy shifter, so ready stays low
        repeat (2)
        begin
            b = 8'($urandom());
            tx_q.push_back(b);
            access(1'b1, 8'h08, b);
        end
        rd(8'h09, 8'h00);
        wait_for(1'b0);
        rd(8'h09, 8'h06);
        $display("transmit done");
        access(1'b1, 8'h09, 8'h80);
        b = 8'($urandom());
        i_mur_midi_peer.send(b);
        wait_for(1'b1);
        rd(8'h09, 8'h83);
        rd(8'h08, b);
        rd(8'h09, 8'h02);
        $display("receive done");
        access(1'b1, 8'h0a, 8'h00);
        fast <= 1'b0;
        rd(8'h0a, 8'h00);
        b = 8'($urandom());
        tx_q.push_back(b);
        access(1'b1, 8'h08, b);
        wait_for(1'b0);
        $display("normal rate done");
        i_mur_midi_peer.send(8'($urandom()));
        wait_for(1'b1);
        access(1'b1, 8'h09, 8'h03);
        rd(8'h09, 8'h02);
        port_enable <= 1'b0;
        rd(8'h09, 8'h00);
        repeat (2) @(posedge mclk);
        $display("reset and enable done");
        test_done();
    end
endmodule : test_midi_uart_regs
bind mur_midi_uart mur_midi_uart_properties i_mur_midi_uart_properties (.mclk(mclk),
    .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
    .io_rdata(io_rdata), .port_enable(port_enable), .midi_in(midi_in),
    .midi_out(midi_out), .serial_irq(serial_irq));
